//--- include/spg_regs.svh
// constants of the serial protocol guard: opcodes, status layout, reset values, counts
// assumes nothing beyond being included once per compilation unit
`ifndef SPG_REGS_SVH
`define SPG_REGS_SVH

// --------------------------------------------------------------
// opcodes
// --------------------------------------------------------------
`define SPG_OP_PERMIT      8'h06
`define SPG_OP_REVOKE      8'h04
`define SPG_OP_FETCH       8'h05
`define SPG_OP_UPDATE      8'h01
`define SPG_OP_READ        8'h03
`define SPG_OP_WRITE       8'h02

// --------------------------------------------------------------
// status byte layout
// --------------------------------------------------------------
`define SPG_ST_LOCK        7
`define SPG_ST_GUARD_HI    3
`define SPG_ST_GUARD_LO    2
`define SPG_ST_PERMIT      1
`define SPG_ST_BUSY        0

// --------------------------------------------------------------
// frame lengths in clock pulses
// --------------------------------------------------------------
`define SPG_LEN_OPCODE     16'h0008
`define SPG_LEN_UPDATE     16'h0010
`define SPG_LEN_ADDR_A14   16'h000a
`define SPG_LEN_READ       16'h0018
`define SPG_LEN_WRITE_MIN  16'h0020

// --------------------------------------------------------------
// reset values and timing
// --------------------------------------------------------------
`define SPG_RST_STATUS     8'h00
`define SPG_BUSY_CYCLES    16'h0040

`endif

//--- include/spg_pkg.sv
// types shared by the serial protocol guard
// assumes spg_regs.svh sits on the include path
package spg_pkg;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_PERMIT,
        CMD_REVOKE,
        CMD_FETCH,
        CMD_UPDATE,
        CMD_READ,
        CMD_WRITE
    } spg_cmd_e;

    // nonvolatile status bits
    typedef struct packed {
        logic lock;
        logic guardHi;
        logic guardLo;
    } spg_nv_s;

    // frame state built on link clock rising edges
    typedef struct packed {
        logic        tag;
        logic [15:0] cnt;
        logic        geq32;
        logic        invalid;
        spg_cmd_e    cmd;
        logic [7:0]  shift;
        logic [7:0]  data;
        logic [1:0]  addrHi;
    } spg_frame_s;

    typedef struct packed {
        logic       rstS1;
        logic       rstS2;
        logic       armS1;
        logic       armS2;
        spg_frame_s fr;
    } spg_link_s;

    typedef struct packed {
        logic [7:0] statS1;
        logic [7:0] statS2;
        logic [7:0] rdS1;
        logic [7:0] rdS2;
    } spg_sync_s;

    typedef struct packed {
        logic bitOut;
        logic en;
    } spg_out_s;

    typedef struct packed {
        logic        csS1;
        logic        csS2;
        logic        csPrev;
        logic        wpS1;
        logic        wpS2;
        logic        armed;
        logic        frameTag;
        logic        permit;
        logic        busy;
        logic [15:0] busyCnt;
        spg_nv_s     nv;
        logic        hardGuard;
        logic        writeGo;
    } spg_sys_s;

endpackage

//--- verilog/spg_protocol_guard.sv
// serial slave front end of a byte-wide nonvolatile memory: shifting, pause,
// selection, write permit, frame checks and area guarding
// assumes the master clocks linkClk only around its own frames and that the
// array engine supplies arrayReadByte on sys_clk
//
// Behaviour
// - bytes move most significant bit first in both directions
// - first input bit is taken on first rising link edge after select
// - fetch data leaves msb first from first falling edge after opcode, read data from first falling edge after address
// - capture on rising link edges, drive serialOut from falling edges
// - after power-up the reset value counts as a deselect, so no select falling edge is needed before selection
// - after power-on clear: standby, deselected, not paused, instructions ignored
// - power-on clear zeroes permit and busy, keeps nonvolatile bits
// - below threshold the device answers no instruction
// - while paused serialOut floats and serialIn and clock are ignored
// - pause starts when pauseN falls with clock low; position kept
// - pause ends when pauseN rises with clock low; sequence resumes
// - deselect while paused resets protocol state; an instruction already of valid length still executes
// - write and status update frames need pulse counts that are multiples of eight
// - modifying commands need the permit latch, set only by permit command
// - permit latch clears at power-up, revoke, update and write completion
// - deselect must fall between last bit edge and next edge to execute
// - last bit is opcode or data byte bit eight; reads are exempt
// - guard bits 00 none, 01 upper quarter, 10 upper half, 11 all
// - protect pin can lock guard bits, giving hard guard mode
// - lock bit set and protect pin low make status bits read-only
// - unknown opcode makes the device ignore the rest of the frame
`timescale 1ns/1ps
`include "spg_regs.svh"

module spg_protocol_guard #(
    parameter logic [15:0] BUSY_CYCLES = `SPG_BUSY_CYCLES
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             linkClk,
    input  wire logic             chipEnableLowN,
    input  wire logic             serialIn,
    input  wire logic             pauseN,
    input  wire logic             protectPinN,
    input  wire spg_pkg::spg_nv_s nvStatusIn,
    input  wire logic [7:0]       arrayReadByte,
    output logic                  serialOut,
    output logic                  serialOutEn,
    output logic                  modifyPermitLatch,
    output logic                  cycleBusyFlag,
    output logic                  hardGuardMode,
    output logic                  arrayWriteGo,
    output spg_pkg::spg_nv_s      nvStatusOut
);
    import spg_pkg::*;

    // --------------------------------------------------------------
    // link domain: rising edges build the frame
    // --------------------------------------------------------------
    spg_link_s  l_q;
    spg_link_s  l_d;
    spg_sys_s   s_q;
    spg_sys_s   s_d;
    logic [15:0] newCnt;
    logic [7:0]  newShift;
    logic        fresh_q;
    logic        fresh_d;

    always_comb begin
        l_d      = l_q;
        fresh_d  = fresh_q;
        newCnt   = l_q.fr.cnt + 16'h0001;
        newShift = {l_q.fr.shift[6:0], serialIn};
        l_d.rstS1 = reset;
        l_d.rstS2 = l_q.rstS1;
        l_d.armS1 = s_q.armed;
        l_d.armS2 = l_q.armS1;
        if (l_q.rstS2) begin
            // tag 0 matches the cleared sys tag, so nothing commits before a frame
            l_d.fr         = '0;
            l_d.fr.invalid = 1'b1;
            fresh_d        = 1'b1;
        end else if (!chipEnableLowN && l_q.armS2 && pauseN) begin
            fresh_d = 1'b0;
            if (fresh_q) begin
                // first rising edge of a fresh select; the new tag tells the sys side
                l_d.fr       = '0;
                l_d.fr.tag   = ~l_q.fr.tag;
                l_d.fr.cnt   = 16'h0001;
                l_d.fr.shift = {7'h00, serialIn};
            end else if (!l_q.fr.invalid) begin
                l_d.fr.cnt   = newCnt;
                l_d.fr.shift = newShift;
                if (newCnt == `SPG_LEN_OPCODE) begin
                    if (newShift == `SPG_OP_PERMIT) begin
                        l_d.fr.cmd = CMD_PERMIT;
                    end else if (newShift == `SPG_OP_REVOKE) begin
                        l_d.fr.cmd = CMD_REVOKE;
                    end else if (newShift == `SPG_OP_FETCH) begin
                        l_d.fr.cmd = CMD_FETCH;
                    end else if (newShift == `SPG_OP_UPDATE) begin
                        l_d.fr.cmd = CMD_UPDATE;
                    end else if (newShift == `SPG_OP_READ) begin
                        l_d.fr.cmd = CMD_READ;
                    end else if (newShift == `SPG_OP_WRITE) begin
                        l_d.fr.cmd = CMD_WRITE;
                    end else begin
                        l_d.fr.invalid = 1'b1;
                    end
                end
                if (newCnt == `SPG_LEN_ADDR_A14) begin
                    l_d.fr.addrHi = newShift[1:0];
                end
                if (newCnt == `SPG_LEN_UPDATE) begin
                    l_d.fr.data = newShift;
                end
                if (newCnt == `SPG_LEN_WRITE_MIN) begin
                    l_d.fr.geq32 = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge linkClk) begin
        l_q <= l_d;
    end

    // deselect marks the next accepted edge as bit one; no link edge is needed
    // between frames, since the master parks the clock there
    always_ff @(posedge linkClk or posedge chipEnableLowN) begin
        if (chipEnableLowN) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= fresh_d;
        end
    end

    // --------------------------------------------------------------
    // link domain: falling edges drive serialOut
    // --------------------------------------------------------------
    spg_sync_s  y_q;
    spg_sync_s  y_d;
    spg_out_s   o_q;
    spg_out_s   o_d;
    logic       outKill;
    logic [2:0] bitSel;
    logic       isFetch;
    logic       isRead;

    assign outKill = chipEnableLowN | ~pauseN;

    always_comb begin
        y_d        = y_q;
        y_d.statS1 = {s_q.nv.lock, 3'h0, s_q.nv.guardHi, s_q.nv.guardLo,
                      s_q.permit, s_q.busy};
        y_d.statS2 = y_q.statS1;
        y_d.rdS1   = arrayReadByte;
        y_d.rdS2   = y_q.rdS1;
    end

    always_ff @(negedge linkClk) begin
        y_q <= y_d;
    end

    always_comb begin
        o_d     = o_q;
        bitSel  = 3'h7 - l_q.fr.cnt[2:0];
        isFetch = (l_q.fr.cmd == CMD_FETCH) && (l_q.fr.cnt >= `SPG_LEN_OPCODE);
        // the sticky flag keeps long reads going once the count wraps
        isRead  = (l_q.fr.cmd == CMD_READ)
                  && (l_q.fr.geq32 || l_q.fr.cnt >= `SPG_LEN_READ);
        if (l_q.fr.invalid || fresh_q) begin
            o_d.en     = 1'b0;
            o_d.bitOut = 1'b0;
        end else if (isFetch) begin
            o_d.en     = 1'b1;
            o_d.bitOut = y_q.statS2[bitSel];
        end else if (isRead) begin
            o_d.en     = 1'b1;
            o_d.bitOut = y_q.rdS2[bitSel];
        end else begin
            o_d.en     = 1'b0;
            o_d.bitOut = 1'b0;
        end
    end

    // deselect or pause floats the pin at once, even with the clock parked
    always_ff @(negedge linkClk or posedge outKill) begin
        if (outKill) begin
            o_q <= '0;
        end else begin
            o_q <= o_d;
        end
    end

    // --------------------------------------------------------------
    // sys domain: selection, commit window, permit, guarding
    // --------------------------------------------------------------
    logic commitFire;
    logic frameOk;
    logic lenPermit;
    logic lenUpdate;
    logic lenWrite;
    logic areaHit;

    always_comb begin
        s_d           = s_q;
        s_d.csS1      = chipEnableLowN;
        s_d.csS2      = s_q.csS1;
        s_d.csPrev    = s_q.csS2;
        s_d.wpS1      = protectPinN;
        s_d.wpS2      = s_q.wpS1;
        s_d.writeGo   = 1'b0;
        s_d.hardGuard = s_q.nv.lock & ~s_q.wpS2;
        // the reset value of csS2 arms the device in the first cycle after reset, even with select held low
        s_d.armed     = s_q.armed | s_q.csS2;
        // the frame word is stable: link edges are ignored while deselected
        commitFire = s_q.armed && !s_q.csPrev && s_q.csS2;
        // an unchanged tag means no frame since the last commit: never run it twice
        frameOk    = (l_q.fr.tag != s_q.frameTag) && !l_q.fr.invalid;
        lenPermit  = (l_q.fr.cnt == `SPG_LEN_OPCODE);
        lenUpdate  = (l_q.fr.cnt == `SPG_LEN_UPDATE);
        lenWrite   = (l_q.fr.cnt[2:0] == 3'h0) && l_q.fr.geq32;
        if (s_q.nv.guardHi && s_q.nv.guardLo) begin
            areaHit = 1'b1;
        end else if (s_q.nv.guardHi) begin
            areaHit = l_q.fr.addrHi[1];
        end else if (s_q.nv.guardLo) begin
            areaHit = &l_q.fr.addrHi;
        end else begin
            areaHit = 1'b0;
        end
        // busy end first, so a permit committed in the same cycle wins
        if (s_q.busy) begin
            s_d.busyCnt = s_q.busyCnt - 16'h0001;
            if (s_q.busyCnt == 16'h0001) begin
                s_d.busy   = 1'b0;
                s_d.permit = 1'b0;
            end
        end
        if (commitFire) begin
            s_d.frameTag = l_q.fr.tag;
        end
        if (commitFire && frameOk) begin
            case (l_q.fr.cmd)
                CMD_PERMIT: begin
                    if (lenPermit) begin
                        s_d.permit = 1'b1;
                    end
                end
                CMD_REVOKE: begin
                    if (lenPermit) begin
                        s_d.permit = 1'b0;
                    end
                end
                CMD_UPDATE: begin
                    if (lenUpdate && s_q.permit && !s_q.busy && !s_q.hardGuard) begin
                        s_d.nv.lock    = l_q.fr.data[`SPG_ST_LOCK];
                        s_d.nv.guardHi = l_q.fr.data[`SPG_ST_GUARD_HI];
                        s_d.nv.guardLo = l_q.fr.data[`SPG_ST_GUARD_LO];
                        s_d.busy       = 1'b1;
                        s_d.busyCnt    = BUSY_CYCLES;
                    end
                end
                CMD_WRITE: begin
                    if (lenWrite && s_q.permit && !s_q.busy && !areaHit) begin
                        s_d.writeGo = 1'b1;
                        s_d.busy    = 1'b1;
                        s_d.busyCnt = BUSY_CYCLES;
                    end
                end
                default: begin
                end
            endcase
        end
        if (reset) begin
            // held in power-on clear the device answers nothing
            s_d          = '0;
            s_d.csS1     = 1'b1;
            s_d.csS2     = 1'b1;
            s_d.csPrev   = 1'b1;
            s_d.wpS1     = 1'b1;
            s_d.wpS2     = 1'b1;
            s_d.nv       = nvStatusIn;
        end
    end

    always_ff @(posedge sys_clk) begin
        s_q <= s_d;
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign serialOut         = o_q.bitOut;
    assign serialOutEn       = o_q.en;
    assign modifyPermitLatch = s_q.permit;
    assign cycleBusyFlag     = s_q.busy;
    assign hardGuardMode     = s_q.hardGuard;
    assign arrayWriteGo      = s_q.writeGo;
    assign nvStatusOut       = s_q.nv;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    sequence permitFrame;
        commitFire && frameOk && l_q.fr.cmd == CMD_PERMIT && lenPermit;
    endsequence

    sequence revokeFrame;
        commitFire && frameOk && l_q.fr.cmd == CMD_REVOKE && lenPermit && !s_q.busy;
    endsequence

    sequence blockedUpdate;
        commitFire && l_q.fr.cmd == CMD_UPDATE && s_q.hardGuard && !s_q.busy;
    endsequence

    a_power_clear: assert property (@(posedge sys_clk)
        reset |=> !s_q.permit && !s_q.busy && !s_q.writeGo && s_q.nv == $past(nvStatusIn))
        else $error("power-on clear left permit or busy set");

    a_select_armed: assert property (@(posedge sys_clk) disable iff (reset)
        !s_q.armed |=> !s_q.permit && !s_q.busy)
        else $error("commit before a select edge was seen");

    a_permit_set: assert property (@(posedge sys_clk) disable iff (reset)
        permitFrame |=> s_q.permit)
        else $error("permit frame did not set the latch");

    a_permit_revoke: assert property (@(posedge sys_clk) disable iff (reset)
        revokeFrame |=> !s_q.permit)
        else $error("revoke frame left the latch set");

    a_write_permit: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(s_q.writeGo) |-> $past(s_q.permit) && s_q.busy && s_q.busyCnt == BUSY_CYCLES)
        else $error("write launched without permit");

    a_write_length: assert property (@(posedge sys_clk) disable iff (reset)
        s_q.writeGo |-> $past(l_q.fr.cnt[2:0]) == 3'h0)
        else $error("write launched on a ragged frame");

    a_write_area: assert property (@(posedge sys_clk) disable iff (reset)
        s_q.writeGo |-> !$past(areaHit))
        else $error("write launched into a guarded area");

    a_hard_lock: assert property (@(posedge sys_clk) disable iff (reset)
        blockedUpdate |=> $stable(s_q.nv) && !s_q.busy)
        else $error("status changed under hard guard");

    a_busy_end: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(s_q.busy) && !$past(commitFire) |-> !s_q.permit ##1 !s_q.busy)
        else $error("permit survived the end of a cycle");

    a_frame_start: assert property (@(posedge linkClk)
        fresh_q && !chipEnableLowN && l_q.armS2 && pauseN && !l_q.rstS2
        |=> l_q.fr.cnt == 16'h0001)
        else $error("fresh select did not start at bit one");

    a_pause_freeze: assert property (@(posedge linkClk)
        !pauseN && !l_q.rstS2 |=> $stable(l_q.fr))
        else $error("frame moved while paused");

    a_pause_float: assert property (@(posedge linkClk)
        !pauseN |-> !o_q.en)
        else $error("output driven while paused");

    a_unknown_quiet: assert property (@(negedge linkClk)
        l_q.fr.invalid |=> !o_q.en)
        else $error("output driven after an unknown opcode");

    a_update_length: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(s_q.busy) && !s_q.writeGo |-> $past(lenUpdate) && $past(l_q.fr.cmd) == CMD_UPDATE)
        else $error("status update ran on a wrong frame length");

endmodule

//--- test/spg_link_master.sv
// serial bus master model: frames msb first in mode 0 or mode 3, pause, abort
// assumes a 6 ns link period and that the bench calls its tasks one at a time
`timescale 1ns/1ps

module spg_link_master (
    output logic      linkClk,
    output logic      chipEnableLowN,
    output logic      serialIn,
    output logic      pauseN,
    input  wire logic serialOut,
    input  wire logic serialOutEn
);
    logic cpol;
    logic enSeen;
    logic floatOk;

    initial begin
        cpol = 1'b0;
        linkClk = 1'b0;
        chipEnableLowN = 1'b1;
        serialIn = 1'b0;
        pauseN = 1'b1;
        enSeen = 1'b0;
        floatOk = 1'b1;
    end

    // --------------------------------------------------------------
    // idle level follows the mode
    // --------------------------------------------------------------
    task automatic set_mode(input logic v);
        cpol = v;
        linkClk = v;
    endtask

    task automatic hold_select(input logic v);
        chipEnableLowN = v;
    endtask

    // link edges outside frames, only so the link side can sync reset and arming
    task automatic edges(input int n);
        repeat (n) begin
            #3 linkClk = ~linkClk;
            #3 linkClk = ~linkClk;
        end
    endtask

    // --------------------------------------------------------------
    // one frame; pz > 0 pauses before bit pz, ab deselects during pause
    // --------------------------------------------------------------
    task automatic frame(input logic [39:0] d, input int n, input int pz, input bit ab,
                         output logic [39:0] rd);
        rd = '0;
        enSeen = 1'b0;
        floatOk = 1'b1;
        chipEnableLowN = 1'b0;
        #3;
        for (int i = 0; i < n; i++) begin
            if (pz > 0 && i == pz) begin
                linkClk = 1'b0;
                #3 pauseN = 1'b0;
                #20 floatOk = (serialOutEn === 1'b0);
                repeat (2) begin
                    // toggles while paused must be ignored
                    linkClk = 1'b1;
                    serialIn = ~serialIn;
                    #3 linkClk = 1'b0;
                    #3;
                end
                floatOk = floatOk && (serialOutEn === 1'b0);
                if (ab) begin
                    chipEnableLowN = 1'b1;
                    serialIn = ~serialIn;
                    #3 pauseN = 1'b1;
                    return;
                end
                pauseN = 1'b1;
                #3;
            end
            linkClk = 1'b0;
            serialIn = d[n-1-i];
            #3 linkClk = 1'b1;
            rd = {rd[38:0], serialOut};
            enSeen = enSeen | (serialOutEn === 1'b1);
            #3;
        end
        linkClk = cpol;
        // deselect between last rising edge and the next one
        #2 chipEnableLowN = 1'b1;
        serialIn = ~serialIn;
    endtask
endmodule

//--- test/spg_protocol_guard_bench.sv
// self-checking bench of the protocol guard against a small state model
// assumes spg_pkg and spg_regs.svh compiled first, and the link master model
`timescale 1ns/1ps

module spg_protocol_guard_bench;
    import spg_pkg::*;

    logic        sys_clk;
    logic        reset;
    logic        protectPinN;
    spg_nv_s     nvStatusIn;
    logic [7:0]  arrayReadByte;
    wire         linkClk;
    wire         chipEnableLowN;
    wire         serialIn;
    wire         pauseN;
    wire         serialOut;
    wire         serialOutEn;
    wire         modifyPermitLatch;
    wire         cycleBusyFlag;
    wire         hardGuardMode;
    wire         arrayWriteGo;
    spg_nv_s     nvStatusOut;
    int          fails = 0;
    int          total_checks = 0;
    int          goCount = 0;
    int          go0;
    int          seed = 95074;
    logic [39:0] rd;
    logic        lock, gh, gl, perm, prot;

    spg_protocol_guard #(.BUSY_CYCLES(16'h0010)) uut (
        .sys_clk(sys_clk), .reset(reset), .linkClk(linkClk),
        .chipEnableLowN(chipEnableLowN), .serialIn(serialIn), .pauseN(pauseN),
        .protectPinN(protectPinN), .nvStatusIn(nvStatusIn), .arrayReadByte(arrayReadByte),
        .serialOut(serialOut), .serialOutEn(serialOutEn),
        .modifyPermitLatch(modifyPermitLatch), .cycleBusyFlag(cycleBusyFlag),
        .hardGuardMode(hardGuardMode), .arrayWriteGo(arrayWriteGo),
        .nvStatusOut(nvStatusOut));

    spg_link_master m (
        .linkClk(linkClk), .chipEnableLowN(chipEnableLowN), .serialIn(serialIn),
        .pauseN(pauseN), .serialOut(serialOut), .serialOutEn(serialOutEn));

    always #50 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (arrayWriteGo === 1'b1) begin
            goCount++;
        end
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic sys(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // frame, then a gap long enough to commit and let any busy period end
    task automatic run(input logic [39:0] d, input int n);
        m.frame(d, n, 0, 0, rd);
        sys(8);
        for (int i = 0; i < 40 && cycleBusyFlag !== 1'b0; i++) begin
            @(posedge sys_clk);
        end
        sys(2);
    endtask

    task automatic fetch();
        run({8'h05, 8'h00}, 16);
        check(rd[7:0], {lock, 3'h0, gh, gl, perm, 1'b0});
        check({7'h00, nvStatusOut.lock}, {7'h00, lock});
    endtask

    task automatic update(input logic [7:0] v);
        run({8'h06}, 8);
        run({8'h01, v}, 16);
        // a refused update never completes, so the permit stays set
        perm = lock && !protectPinN;
        if (!perm) begin
            lock = v[7];
            gh = v[3];
            gl = v[2];
        end
        check({7'h00, modifyPermitLatch}, {7'h00, perm});
    endtask

    initial begin
        #3_000_000;
        fails++;
        $display("unexpected at %0t: run did not finish", $time);
        conclude();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        reset = 1'b1;
        protectPinN = 1'b1;
        nvStatusIn = spg_nv_s'($random(seed));
        arrayReadByte = 8'($random(seed));
        m.hold_select(1'b0);
        m.edges(4);
        sys(3);
        reset <= 1'b0;
        sys(6);
        // select low since power-up: the link reset sync takes two edges, so only six bits count and no command
        run(8'h06, 8);
        check({7'h00, modifyPermitLatch}, 8'h00);
        check({5'h00, nvStatusOut}, {5'h00, nvStatusIn});
        check({7'h00, cycleBusyFlag}, 8'h00);
        {lock, gh, gl} = nvStatusIn;
        perm = 1'b0;
        m.edges(4);
        fetch();
        run(8'h06, 9);
        check({7'h00, modifyPermitLatch}, 8'h00);
        run({8'h01, 8'h8c}, 16);
        fetch();
        run(8'h06, 8);
        perm = 1'b1;
        check({7'h00, modifyPermitLatch}, 8'h01);
        run({8'h01, 7'h46}, 15);
        fetch();
        run(8'h04, 8);
        perm = 1'b0;
        fetch();
        for (int g = 0; g < 4; g++) begin
            update({4'h0, g[1:0], 2'b00});
            fetch();
            for (int q = 0; q < 4; q++) begin
                run(8'h06, 8);
                go0 = goCount;
                // protect pin held steady across every write frame
                run({8'h02, q[1:0], 14'($random(seed)), 8'h5a}, 32);
                prot = (g == 3) || (g == 2 && q >= 2) || (g == 1 && q == 3);
                check(8'(goCount - go0), {7'h00, !prot});
                if (!prot) begin
                    check({7'h00, modifyPermitLatch}, 8'h00);
                end
                run(8'h04, 8);
            end
        end
        run(8'h06, 8);
        go0 = goCount;
        run({8'h02, 16'h0010, 8'h5a, 1'b1}, 33);
        check(8'(goCount - go0), 8'h00);
        run(8'h04, 8);
        protectPinN <= 1'b0;
        update(8'h80);
        check({7'h00, hardGuardMode}, 8'h01);
        update(8'h0c);
        check({5'h00, nvStatusOut}, {5'h00, lock, gh, gl});
        run(8'h04, 8);
        perm = 1'b0;
        protectPinN <= 1'b1;
        sys(5);
        check({7'h00, hardGuardMode}, 8'h00);
        update(8'h00);
        fetch();
        run({8'hff, 8'h05}, 16);
        check({7'h00, m.enSeen}, 8'h00);
        m.frame({8'h05, 8'h00}, 16, 11, 0, rd);
        sys(8);
        check(rd[7:0], {lock, 3'h0, gh, gl, perm, 1'b0});
        check({7'h00, m.floatOk}, 8'h01);
        m.frame(8'h06, 8, 4, 1, rd);
        sys(8);
        check({7'h00, modifyPermitLatch}, 8'h00);
        m.set_mode(1'b1);
        fetch();
        arrayReadByte <= 8'($random(seed));
        run({8'h03, 16'h4321, 16'h0000}, 40);
        check(rd[15:8], arrayReadByte);
        check(rd[7:0], arrayReadByte);
        m.set_mode(1'b0);
        reset <= 1'b1;
        nvStatusIn <= spg_nv_s'($random(seed));
        run(8'h06, 8);
        reset <= 1'b0;
        sys(6);
        check({7'h00, modifyPermitLatch}, 8'h00);
        check({5'h00, nvStatusOut}, {5'h00, nvStatusIn});
        {lock, gh, gl} = nvStatusIn;
        m.edges(4);
        fetch();
        conclude();
    end
endmodule
